/* logic/hsc_status_control.v */
/*
  HDLC status word and control register two, idle and abort detection on
  the receive line, underrun detection, transmit byte counter.
  Assumes the FIFOs, receiver, transmitter and interrupt register sit
  outside and run on clk; the receive line clock and data are asynchronous.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hsc_map.vh"

// Notes on behaviour
// R1 - Pending flag sets on any unmasked interrupt, clears when interrupt register read.
// R2 - Idle flag sets after fifteen consecutive ones; may read one after reset.
// R3 - Two-bit tag of next receive byte: packet, first, good last, bad last.
// R4 - Transmit fill code: full level, at threshold, empty, below threshold.
// R5 - Receive fill code: empty, below threshold, full, at or above threshold.
// R6 - Interrupt bit two shows underrun when select high, else frame abort.
// R7 - Repeat bit makes transmit byte counter reload and cycle continuously.
// R8 - Suppress bit stops frame check sequence after end-of-frame byte.
// R9 - Short address mode matches seven bits; needs received bit zero high.
// R10 - Host keeps control two bits three and two at zero.
// R11 - Receive flush reports empty, holds receiver off until next flag.
// R12 - Transmit flush reports empty; self-clears on next transmit FIFO write.
// R13 - Abort counts only after at least 26 packet bits received.
// R14 - Underrun raised when transmitter fetches from empty transmit FIFO.
// R15 - Status register is read-only; writes change nothing.
module hsc_status_control #(
  parameter AW        = 8,
  parameter RX_DEPTH  = 128,
  parameter CW        = 8
) (
  // Clock and reset
  input  wire          clk,
  input  wire          sys_rst,
  // Register port
  input  wire [7:0]    regAddr,
  input  wire [7:0]    regWrData,
  input  wire          regWrEn,
  input  wire          regRdEn,
  output reg  [7:0]    regRdData_ff,
  // Receive line, asynchronous
  input  wire          receiveLineClock,
  input  wire          rxLineData,
  // FIFO state
  input  wire [AW-1:0] txFifoCount,
  input  wire [AW-1:0] rxFifoCount,
  input  wire [AW-1:0] txFullLevel,
  input  wire [AW-1:0] txIrqThresh,
  input  wire [AW-1:0] rxIrqThresh,
  input  wire [1:0]    rxByteTag,
  input  wire          txFifoWrite,
  input  wire          txFetch,
  // Interrupt sources and mask
  input  wire [7:0]    irqEvents,
  input  wire [7:0]    irqMask,
  // Transmitter and receiver hooks
  input  wire [CW-1:0] txByteCountLoad,
  input  wire          txByteSent,
  input  wire          txEndOfFrameSent,
  input  wire          rxAddrValid,
  input  wire [7:0]    rxAddrByte,
  input  wire [6:0]    rxAddrMatch,
  // Outputs to the datapath
  output reg           irqBitTwoEvent_ff,
  output reg           txQueueUnderrun_ff,
  output reg           frameAbortFlag_ff,
  output reg           rxReceiverEnable_ff,
  output reg  [CW-1:0] txByteCount_ff,
  output reg           txCountDone_ff,
  output reg           txAppendFcs_ff,
  output reg           rxShortAddrHit_ff,
  output reg  [7:0]    hdlcControlTwo_ff
);

  // Synchronisers and edge detect
  reg          rxClkMeta_ff;
  reg          rxClkSync_ff;
  reg          rxClkPrev_ff;
  reg          rxDatMeta_ff;
  reg          rxDatSync_ff;
  // Line state
  reg  [7:0]   lineShift_ff;
  reg  [3:0]   onesRun_ff;
  reg  [4:0]   frameBits_ff;
  reg          inFrame_ff;
  reg          idleFlag_ff;
  reg          hdlcIrqPending_ff;
  reg  [1:0]   txFillState;
  reg  [1:0]   rxFillState;
  reg  [7:0]   nxt_lineShift;
  reg          nxt_abortHit;

  wire         lineBitStrobe = rxClkSync_ff & ~rxClkPrev_ff;
  wire         flagSeen      = (nxt_lineShift == `HSC_FLAG_PATTERN);
  wire         intSel        = hdlcControlTwo_ff[`HSC_C2_INTSEL_BIT];
  wire         countRepeat   = hdlcControlTwo_ff[`HSC_C2_REPEAT_BIT];
  wire         fcsSuppress   = hdlcControlTwo_ff[`HSC_C2_FCSOFF_BIT];
  wire         shortAddr     = hdlcControlTwo_ff[`HSC_C2_SHORT_BIT];
  wire         rxQueueFlush  = hdlcControlTwo_ff[`HSC_C2_RXFLUSH_BIT];
  wire         txQueueFlush  = hdlcControlTwo_ff[`HSC_C2_TXFLUSH_BIT];
  wire         txEmpty       = txQueueFlush | (txFifoCount == {AW{1'b0}});
  wire         underrunEv    = txFetch & txEmpty; // R14
  wire         abortEv       = nxt_abortHit & lineBitStrobe;
  wire         bitTwoEv      = intSel ? underrunEv : abortEv; // R6
  wire [7:0]   liveEvents    = {irqEvents[7:3], bitTwoEv, irqEvents[1:0]};
  wire         irqRead       = regRdEn & (regAddr == `HSC_IRQ_STAT_OFS);
  wire         ctrlWrite     = regWrEn & (regAddr == `HSC_CTRL2_OFS);

  // Abort: seventh consecutive one inside a frame of 26 bits or more
  always @* begin
    nxt_lineShift = {lineShift_ff[6:0], rxDatSync_ff};
    nxt_abortHit  = inFrame_ff & rxDatSync_ff &
                    (onesRun_ff == `HSC_ABORT_ONES - 4'h1) &
                    (frameBits_ff >= `HSC_ABORT_MIN_BITS); // R13
  end

  // Fill state codes
  always @* begin
    if (txEmpty)
      txFillState = `HSC_TX_EMPTY; // R12
    else if (txFifoCount >= txFullLevel)
      txFillState = `HSC_TX_FULL_LVL; // R4
    else if (txFifoCount >= txIrqThresh)
      txFillState = `HSC_TX_AT_THR; // R4
    else
      txFillState = `HSC_TX_BELOW_THR; // R4
    if (rxQueueFlush || rxFifoCount == {AW{1'b0}})
      rxFillState = `HSC_RX_EMPTY; // R11
    else if (rxFifoCount >= RX_DEPTH[AW-1:0])
      rxFillState = `HSC_RX_FULL; // R5
    else if (rxFifoCount >= rxIrqThresh)
      rxFillState = `HSC_RX_AT_THR; // R5
    else
      rxFillState = `HSC_RX_BELOW_THR; // R5
  end

  // Input synchronisers
  always @(posedge clk) begin
    if (sys_rst) begin
      rxClkMeta_ff <= 1'b0;
      rxClkSync_ff <= 1'b0;
      rxClkPrev_ff <= 1'b0;
      rxDatMeta_ff <= 1'b0;
      rxDatSync_ff <= 1'b0;
    end else begin
      rxClkMeta_ff <= receiveLineClock;
      rxClkSync_ff <= rxClkMeta_ff;
      rxClkPrev_ff <= rxClkSync_ff;
      rxDatMeta_ff <= rxLineData;
      rxDatSync_ff <= rxDatMeta_ff;
    end
  end

  // Receive line watcher
  always @(posedge clk) begin
    if (sys_rst) begin
      lineShift_ff <= 8'h00;
      onesRun_ff   <= 4'h0;
      frameBits_ff <= 5'h00;
      inFrame_ff   <= 1'b0;
      idleFlag_ff  <= 1'b1;
    end else if (lineBitStrobe) begin
      lineShift_ff <= nxt_lineShift;
      if (!rxDatSync_ff) begin
        onesRun_ff  <= 4'h0;
        idleFlag_ff <= 1'b0; // R2
      end else if (onesRun_ff != `HSC_IDLE_ONES) begin
        onesRun_ff  <= onesRun_ff + 4'h1;
        idleFlag_ff <= (onesRun_ff == `HSC_IDLE_ONES - 4'h1); // R2
      end
      if (flagSeen) begin
        inFrame_ff   <= 1'b1;
        frameBits_ff <= 5'h00;
      end else if (nxt_abortHit || (rxDatSync_ff && onesRun_ff >= `HSC_ABORT_ONES)) begin
        inFrame_ff   <= 1'b0;
      end else if (frameBits_ff != 5'h1F) begin
        frameBits_ff <= frameBits_ff + 5'h01;
      end
    end
  end

  // Control register two and pending flag
  always @(posedge clk) begin
    if (sys_rst) begin
      hdlcControlTwo_ff   <= `HSC_CTRL2_RESET;
      hdlcIrqPending_ff   <= 1'b0;
      rxReceiverEnable_ff <= 1'b1;
    end else begin
      if (ctrlWrite)
        hdlcControlTwo_ff <= regWrData;
      else if (txFifoWrite)
        hdlcControlTwo_ff[`HSC_C2_TXFLUSH_BIT] <= 1'b0; // R12
      if (|(liveEvents & irqMask))
        hdlcIrqPending_ff <= 1'b1; // R1
      else if (irqRead)
        hdlcIrqPending_ff <= 1'b0; // R1
      if (rxQueueFlush)
        rxReceiverEnable_ff <= 1'b0; // R11
      else if (lineBitStrobe && flagSeen)
        rxReceiverEnable_ff <= 1'b1; // R11
    end
  end

  // Events, transmit counter, address check
  always @(posedge clk) begin
    if (sys_rst) begin
      irqBitTwoEvent_ff  <= 1'b0;
      txQueueUnderrun_ff <= 1'b0;
      frameAbortFlag_ff  <= 1'b0;
      txByteCount_ff     <= {CW{1'b0}};
      txCountDone_ff     <= 1'b0;
      txAppendFcs_ff     <= 1'b0;
      rxShortAddrHit_ff  <= 1'b0;
    end else begin
      irqBitTwoEvent_ff  <= bitTwoEv; // R6
      txQueueUnderrun_ff <= underrunEv; // R14
      frameAbortFlag_ff  <= abortEv; // R13
      txAppendFcs_ff     <= txEndOfFrameSent & ~fcsSuppress; // R8
      rxShortAddrHit_ff  <= rxAddrValid & shortAddr & rxAddrByte[0] &
                            (rxAddrByte[7:1] == rxAddrMatch); // R9
      txCountDone_ff     <= 1'b0;
      if (txByteSent) begin
        if (txByteCount_ff == {{(CW-1){1'b0}}, 1'b1}) begin
          txCountDone_ff <= 1'b1;
          txByteCount_ff <= countRepeat ? txByteCountLoad : {CW{1'b0}}; // R7
        end else if (txByteCount_ff != {CW{1'b0}}) begin
          txByteCount_ff <= txByteCount_ff - {{(CW-1){1'b0}}, 1'b1};
        end else if (countRepeat) begin
          txByteCount_ff <= txByteCountLoad; // R7
        end
      end
    end
  end

  // Read data; status offset ignores writes
  always @(posedge clk) begin
    if (sys_rst) begin
      regRdData_ff <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `HSC_STATUS_OFS: regRdData_ff <= {hdlcIrqPending_ff, idleFlag_ff,
                                          rxByteTag, txFillState, rxFillState}; // R3
        `HSC_CTRL2_OFS:  regRdData_ff <= hdlcControlTwo_ff;
        default:         regRdData_ff <= 8'h00;
      endcase
    end
  end

endmodule // hsc_status_control
`default_nettype wire

/* include/hsc_map.vh */
/*
  Register offsets, bit positions, reset values and timing counts for the
  HDLC status and control block. Assumes inclusion by bare name.
*/
`ifndef HSC_MAP_VH
`define HSC_MAP_VH

// Register offsets
`define HSC_STATUS_OFS      8'h14
`define HSC_CTRL2_OFS       8'h15
`define HSC_IRQ_STAT_OFS    8'h17

// Status word bit positions
`define HSC_ST_IRQ_BIT      7
`define HSC_ST_IDLE_BIT     6
`define HSC_ST_TAG_HI       5
`define HSC_ST_TAG_LO       4
`define HSC_ST_TXF_HI       3
`define HSC_ST_TXF_LO       2
`define HSC_ST_RXF_HI       1
`define HSC_ST_RXF_LO       0

// Control two bit positions and reset value
`define HSC_C2_INTSEL_BIT   7
`define HSC_C2_REPEAT_BIT   6
`define HSC_C2_FCSOFF_BIT   5
`define HSC_C2_SHORT_BIT    4
`define HSC_C2_RXFLUSH_BIT  1
`define HSC_C2_TXFLUSH_BIT  0
`define HSC_CTRL2_RESET     8'h00

// Fill state codes
`define HSC_TX_FULL_LVL     2'h0
`define HSC_TX_AT_THR       2'h1
`define HSC_TX_EMPTY        2'h2
`define HSC_TX_BELOW_THR    2'h3
`define HSC_RX_EMPTY        2'h0
`define HSC_RX_BELOW_THR    2'h1
`define HSC_RX_FULL         2'h2
`define HSC_RX_AT_THR       2'h3

// Line timing counts in received bits, flag pattern and abort interrupt bit
`define HSC_IDLE_ONES       4'hF
`define HSC_ABORT_ONES      4'h7
`define HSC_ABORT_MIN_BITS  5'h1A
`define HSC_FLAG_PATTERN    8'h7E
`define HSC_IRQ_ABORT_BIT   2

`endif

/* tb/hsc_checker.sv */
/* Port checker for hsc_status_control.
   Sees its ports only; bound after the module. */
`timescale 1ns/100ps
`default_nettype none
module hsc_checker #(parameter AW = 8, parameter CW = 8) (
  // Strobes and flags
  input wire logic          clk, sys_rst, regWrEn, regRdEn, txFifoWrite, txFetch,
  input wire logic          txByteSent, txEndOfFrameSent, rxAddrValid, irqBitTwoEvent_ff,
  input wire logic          txQueueUnderrun_ff, frameAbortFlag_ff, rxReceiverEnable_ff,
  input wire logic          txCountDone_ff, txAppendFcs_ff, rxShortAddrHit_ff,
  // Buses
  input wire logic [7:0]    regAddr, regWrData, regRdData_ff, rxAddrByte, hdlcControlTwo_ff,
  input wire logic [6:0]    rxAddrMatch,
  input wire logic [AW-1:0] txFifoCount,
  input wire logic [CW-1:0] txByteCountLoad, txByteCount_ff
);
  logic          shortOk;
  logic          fcsOn;
  logic [CW-1:0] reloadVal;
  assign shortOk = rxAddrByte[0] && rxAddrByte[7:1] == rxAddrMatch;
  assign fcsOn = !hdlcControlTwo_ff[5];
  assign reloadVal = hdlcControlTwo_ff[6] ? txByteCountLoad : '0;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_txfWrite; txFifoWrite && !regWrEn && hdlcControlTwo_ff[0]; endsequence
  sequence s_lastByte; txByteSent && txByteCount_ff == 1; endsequence
  property p_und; txFetch && txFifoCount == 0 |=> txQueueUnderrun_ff; endproperty
  a_und: assert property (p_und) else $error("underrun missed");
  property p_selUnd; txQueueUnderrun_ff && hdlcControlTwo_ff[7] |-> ##[0:1] irqBitTwoEvent_ff;
  endproperty
  a_selUnd: assert property (p_selUnd) else $error("bit two lost underrun");
  property p_selAbt; frameAbortFlag_ff && !hdlcControlTwo_ff[7] |-> ##[0:1] irqBitTwoEvent_ff;
  endproperty
  a_selAbt: assert property (p_selAbt) else $error("bit two lost abort");
  property p_fcs; txEndOfFrameSent |=> txAppendFcs_ff == $past(fcsOn); endproperty
  a_fcs: assert property (p_fcs) else $error("fcs append wrong");
  property p_flush; s_txfWrite |=> !hdlcControlTwo_ff[0]; endproperty
  a_flush: assert property (p_flush) else $error("tx flush kept");
  property p_wr; regWrEn && regAddr == 8'h15 |=> hdlcControlTwo_ff == $past(regWrData);
  endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  property p_rd; regRdEn && regAddr == 8'h15 |=> regRdData_ff == $past(hdlcControlTwo_ff);
  endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  property p_rxOff; hdlcControlTwo_ff[1] |=> !rxReceiverEnable_ff; endproperty
  a_rxOff: assert property (p_rxOff) else $error("receiver on in flush");
  property p_short; rxAddrValid && hdlcControlTwo_ff[4] |=> rxShortAddrHit_ff == $past(shortOk);
  endproperty
  a_short: assert property (p_short) else $error("short match wrong");
  property p_cnt; s_lastByte |=> txCountDone_ff && txByteCount_ff == $past(reloadVal);
  endproperty
  a_cnt: assert property (p_cnt) else $error("count wrap wrong");
endmodule // hsc_checker

bind hsc_status_control hsc_checker #(.AW(AW), .CW(CW)) u_chk (.clk, .sys_rst, .regWrEn,
  .regRdEn, .txFifoWrite, .txFetch, .txByteSent, .txEndOfFrameSent, .rxAddrValid,
  .irqBitTwoEvent_ff, .txQueueUnderrun_ff, .frameAbortFlag_ff, .rxReceiverEnable_ff,
  .txCountDone_ff, .txAppendFcs_ff, .rxShortAddrHit_ff, .regAddr, .regWrData, .regRdData_ff,
  .rxAddrByte, .hdlcControlTwo_ff, .rxAddrMatch, .txFifoCount, .txByteCountLoad, .txByteCount_ff);
`default_nettype wire

/* tb/hsc_line_peer.sv */
/* Remote HDLC peer on the receive line.
   Sends bytes MSB first; line clock stands still between calls. */
`timescale 1ns/100ps
`default_nettype none
module hsc_line_peer (
  // Serial line
  output var logic lineClk,
  output var logic lineData
);
  initial begin
    lineClk = 1'b0;
    lineData = 1'b1;
  end
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      lineData = b[i];
      #62.5 lineClk = 1'b1;
      #62.5 lineClk = 1'b0;
    end
    lineData = ~b[0];
  endtask
endmodule // hsc_line_peer
`default_nettype wire

/* tb/tb_top.sv */
/* Testbench for hsc_status_control.
   Needs hsc_line_peer and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
`include "hsc_map.vh"
module tb_top;
  localparam logic [7:0] ST = `HSC_STATUS_OFS, C2 = `HSC_CTRL2_OFS, IR = `HSC_IRQ_STAT_OFS;
  logic       clk = 1'b0, sys_rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rxAddrByte = 8'h00, rdData;
  logic [7:0] txCnt = 8'h00, rxCnt = 8'h00;
  logic [4:0] pl = 5'h00;
  logic [1:0] tag = 2'h0;
  logic [7:0] irqEv = 8'h00, irqMsk = 8'h04, ld = 8'h03;
  wire  [7:0] rdBus, ctrl, cnt;
  wire        lineClk, lineData, rxEn, und, abt, bit2, done, fcs, hit;
  int         err_count = 0, checks_done = 0, nAbt = 0, nUnd = 0, nB2 = 0, nDone = 0;
  int         nFcs = 0, nHit = 0;
  hsc_status_control DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData_ff(rdBus),
    .receiveLineClock(lineClk), .rxLineData(lineData), .txFifoCount(txCnt),
    .rxFifoCount(rxCnt), .txFullLevel(8'h08), .txIrqThresh(8'h04), .rxIrqThresh(8'h04),
    .rxByteTag(tag), .txFifoWrite(pl[0]), .txFetch(pl[1]), .irqEvents(irqEv),
    .irqMask(irqMsk), .txByteCountLoad(ld), .txByteSent(pl[2]), .txEndOfFrameSent(pl[3]),
    .rxAddrValid(pl[4]), .rxAddrByte(rxAddrByte), .rxAddrMatch(7'h2A),
    .irqBitTwoEvent_ff(bit2), .txQueueUnderrun_ff(und), .frameAbortFlag_ff(abt),
    .rxReceiverEnable_ff(rxEn), .txByteCount_ff(cnt), .txCountDone_ff(done),
    .txAppendFcs_ff(fcs), .rxShortAddrHit_ff(hit), .hdlcControlTwo_ff(ctrl));
  hsc_line_peer peer (.lineClk(lineClk), .lineData(lineData));
  always #5 clk = ~clk;
  always @(posedge clk) begin
    nAbt += abt;
    nUnd += und;
    nB2 += bit2;
    nDone += done;
    nFcs += fcs;
    nHit += hit;
  end
  task automatic chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic [7:0] a, d, input logic wr);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = wr;
    regRdEn = ~wr;
    @(negedge clk);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    rdData = rdBus;
  endtask
  task automatic pulse(input logic [4:0] m);
    @(negedge clk);
    pl = m;
    @(negedge clk);
    pl = 5'h00;
  endtask
  task automatic line(input logic [7:0] b);
    peer.sendByte(b);
    repeat (10) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset;
    acc(C2, 8'h00, 1'b0);
    chk(rdData, 8'h00);
    acc(ST, 8'hFF, 1'b1);
    acc(ST, 8'h00, 1'b0);
    chk(rdData, 8'h48);
    acc(8'h20, 8'h00, 1'b0);
    chk(rdData, 8'h00);
    chk({7'h00, rxEn}, 8'h01);
    $display("Test reset done");
  endtask
  task automatic t_fill;
    logic [7:0] tc[4] = '{8'h00, 8'h02, 8'h04, 8'h08};
    logic [7:0] rc[4] = '{8'h00, 8'h02, 8'h04, 8'h80};
    logic [7:0] ex[4] = '{8'h08, 8'h1D, 8'h27, 8'h32};
    for (int i = 0; i < 4; i++) begin
      txCnt = tc[i];
      rxCnt = rc[i];
      tag = 2'(i);
      acc(ST, 8'h00, 1'b0);
      chk({2'h0, rdData[5:0]}, ex[i]);
    end
    $display("Test fill done");
  endtask
  task automatic t_flush;
    acc(C2, 8'h03, 1'b1);
    acc(ST, 8'h00, 1'b0);
    chk({4'h0, rdData[3:0]}, 8'h08);
    pulse(5'h01);
    acc(C2, 8'h00, 1'b0);
    chk(rdData, 8'h02);
    acc(C2, 8'h00, 1'b1);
    chk({7'h00, rxEn}, 8'h00);
    line(`HSC_FLAG_PATTERN);
    chk({7'h00, rxEn}, 8'h01);
    $display("Test flush done");
  endtask
  task automatic t_line;
    peer.sendByte(8'h3F);
    line(8'hFF);
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[6]}, 8'h00);
    line(8'hFF);
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[6]}, 8'h01);
    for (int k = 2; k <= 3; k++) begin
      peer.sendByte(`HSC_FLAG_PATTERN);
      repeat (k) peer.sendByte(8'h00);
      line(8'hFE);
    end
    chk(8'(nAbt), 8'h01);
    chk(8'(nB2), 8'h01);
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[7]}, 8'h01);
    acc(IR, 8'h00, 1'b0);
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[7]}, 8'h00);
    // Masked event and outside bit two must not set pending
    @(negedge clk);
    irqEv = 8'h14;
    @(negedge clk);
    irqEv = 8'h00;
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[7]}, 8'h00);
    // Unmasked outside event sets pending
    irqMsk = 8'h14;
    @(negedge clk);
    irqEv = 8'h10;
    @(negedge clk);
    irqEv = 8'h00;
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[7]}, 8'h01);
    acc(IR, 8'h00, 1'b0);
    irqMsk = 8'h04;
    acc(ST, 8'h00, 1'b0);
    chk({7'h00, rdData[7]}, 8'h00);
    $display("Test line done");
  endtask
  task automatic t_tx;
    acc(C2, 8'h80, 1'b1);
    txCnt = 8'h05;
    pulse(5'h02);
    txCnt = 8'h00;
    pulse(5'h02);
    repeat (3) @(negedge clk);
    chk(8'(nUnd), 8'h01);
    chk(8'(nB2), 8'h02);
    acc(C2, 8'h40, 1'b1);
    repeat (4) pulse(5'h04);
    chk(cnt, 8'h03);
    acc(C2, 8'h20, 1'b1);
    repeat (3) pulse(5'h04);
    pulse(5'h08);
    chk(cnt, 8'h00);
    chk(8'(nDone), 8'h02);
    acc(C2, 8'h10, 1'b1);
    pulse(5'h08);
    // Let the pulse counter see the registered flag
    @(negedge clk);
    chk(8'(nFcs), 8'h01);
    rxAddrByte = 8'h55;
    pulse(5'h10);
    rxAddrByte = 8'h54;
    pulse(5'h10);
    chk(8'(nHit), 8'h01);
    $display("Test transmit done");
  endtask
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    t_reset;
    t_fill;
    t_flush;
    t_line;
    t_tx;
    stop_test;
  end
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
